/* File: hw/hub_pin_defs.svh */
`ifndef HUB_PIN_DEFS_SVH
`define HUB_PIN_DEFS_SVH

// number of downstream ports
`define HUB_NUM_PORTS 3
// index (0 based) of the port that has no disable strap
`define HUB_NOSTRAP_PORT 2
// reset value of the pin function select: general interrupt
`define HUB_IRQ_FUNC_RESET 1'b0

`endif

/* File: hw/hub_pin_pkg.sv */
package hub_pin_pkg;

  typedef enum logic {
    IRQ_FUNC_GENERAL,
    IRQ_FUNC_SUSPEND
  } irq_func_t;

  typedef enum logic [1:0] {
    ST_IN_RESET,
    ST_SAMPLE,
    ST_RUN
  } hub_state_t;

endpackage

/* File: hw/strap_sample_if.sv */
interface strap_sample_if #(parameter int NUM_PORTS = 3);
  logic sample_pulse;
  logic [NUM_PORTS-1:0] dplus;
  logic [NUM_PORTS-1:0] dminus;
  logic [NUM_PORTS-1:0] port_disabled;

  modport ctrl (output sample_pulse, output dplus, output dminus, input port_disabled);
  modport latch (input sample_pulse, input dplus, input dminus, output port_disabled);
endinterface

/* File: hw/strap_latch.sv */
`include "hub_pin_defs.svh"

module strap_latch #(
  parameter int NUM_PORTS = `HUB_NUM_PORTS,
  parameter int NOSTRAP_PORT = `HUB_NOSTRAP_PORT
) (
  input wire logic clk,
  input wire logic reset_n,
  strap_sample_if.latch sif
);
  import hub_pin_pkg::*;

  logic [NUM_PORTS-1:0] disabled_ff;
  logic [NUM_PORTS-1:0] nxt_disabled;

  genvar i;
  generate
    for (i = 0; i < NUM_PORTS; i++) begin : g_port
      if (i == NOSTRAP_PORT) begin : g_none
        // no strap here: configuration alone decides
        assign nxt_disabled[i] = 1'b0;
      end else begin : g_strap
        wire both_high = sif.dplus[i] & sif.dminus[i];
        assign nxt_disabled[i] = sif.sample_pulse ? both_high : disabled_ff[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      disabled_ff <= '0;
    end else begin
      disabled_ff <= nxt_disabled;
    end
  end

  assign sif.port_disabled = disabled_ff;
endmodule

/* File: hw/hub_strap_and_irq_pin.sv */
`include "hub_pin_defs.svh"

module hub_strap_and_irq_pin #(
  parameter int NUM_PORTS = `HUB_NUM_PORTS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [NUM_PORTS-1:0] downstream_port_dplus,
  input wire logic [NUM_PORTS-1:0] downstream_port_dminus,
  input wire logic irq_pin_function_select,
  input wire logic status_update,
  input wire logic irq_status_write,
  input wire logic hub_configured,
  input wire logic hub_suspended,
  output logic [NUM_PORTS-1:0] strap_port_disabled,
  output logic standby,
  output logic irq_pin_out,
  output logic irq_pin_oe
);
  import hub_pin_pkg::*;

  strap_sample_if #(
    .NUM_PORTS(NUM_PORTS)
  ) sif ();

  // synchronised pin levels, gathered from the per-pin stages below
  wire [NUM_PORTS-1:0] dplus_sync;
  wire [NUM_PORTS-1:0] dminus_sync;

  // reset and capture sequencing
  hub_state_t state_ff;
  hub_state_t nxt_state;
  logic sampling;
  logic running;
  logic standby_ff;
  logic nxt_standby;

  // pin function and the events that move the general flag
  irq_func_t func_sel;
  logic irq_set;
  logic irq_clr;
  logic hub_active;
  logic susp_low;

  // interrupt flag and pin enable
  logic gen_irq_ff;
  logic nxt_gen_irq;
  logic pull_low_ff;
  logic nxt_pull_low;

  // pins are asynchronous to clk: two stages before any use
  // the stages carry no reset, so they keep tracking the pins while reset is held
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_pin_sync
      logic dp_meta_ff;
      logic dp_sync_ff;
      logic dm_meta_ff;
      logic dm_sync_ff;

      always_ff @(posedge clk) begin
        dp_meta_ff <= downstream_port_dplus[p];
      end

      always_ff @(posedge clk) begin
        dp_sync_ff <= dp_meta_ff;
      end

      always_ff @(posedge clk) begin
        dm_meta_ff <= downstream_port_dminus[p];
      end

      always_ff @(posedge clk) begin
        dm_sync_ff <= dm_meta_ff;
      end

      assign dplus_sync[p] = dp_sync_ff;
      assign dminus_sync[p] = dm_sync_ff;
    end
  endgenerate

  // one cycle after release the synced pins still show the level at release
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IN_RESET: begin
        nxt_state = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        // the capture is taken here, once per reset
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        // only a reset leaves the run state
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_IN_RESET;
      end
    endcase
  end

  // an illegal code falls back through the reset state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= ST_IN_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sampling = (state_ff == ST_SAMPLE);
  assign running = (state_ff == ST_RUN);

  // standby comes from a flop of its own rather than a state decode
  assign nxt_standby = (nxt_state == ST_IN_RESET);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      standby_ff <= 1'b1;
    end else begin
      standby_ff <= nxt_standby;
    end
  end

  // the latch only ever sees the synced copies, never a raw pin
  assign sif.sample_pulse = sampling;
  assign sif.dplus = dplus_sync;
  assign sif.dminus = dminus_sync;

  strap_latch #(
    .NUM_PORTS(NUM_PORTS),
    .NOSTRAP_PORT(`HUB_NOSTRAP_PORT)
  ) u_strap (
    .clk(clk),
    .reset_n(reset_n),
    .sif(sif)
  );

  // the disable bits stand until the next reset
  assign strap_port_disabled = sif.port_disabled;
  assign standby = standby_ff;

  // the select is read live: a change shows on the pin one edge later
  assign func_sel = irq_func_t'(irq_pin_function_select);

  // a new update in the clearing cycle wins, so no event is lost
  assign irq_set = status_update;
  assign irq_clr = irq_status_write && !status_update;

  always_comb begin
    nxt_gen_irq = gen_irq_ff;
    if (irq_set) begin
      nxt_gen_irq = 1'b1;
    end else if (irq_clr) begin
      nxt_gen_irq = 1'b0;
    end else begin
      nxt_gen_irq = gen_irq_ff;
    end
  end

  // suspend indication: pulled low unless configured and awake
  assign hub_active = hub_configured && !hub_suspended;
  assign susp_low = !hub_active;

  // the pin stays released until the capture is done and the block runs
  always_comb begin
    nxt_pull_low = 1'b0;
    if (running) begin
      case (func_sel)
        IRQ_FUNC_GENERAL: begin
          nxt_pull_low = nxt_gen_irq;
        end
        IRQ_FUNC_SUSPEND: begin
          nxt_pull_low = susp_low;
        end
        default: begin
          nxt_pull_low = 1'b0;
        end
      endcase
    end
  end

  // general flag: set by updates, cleared by the host write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gen_irq_ff <= 1'b0;
    end else if (!running) begin
      // updates that land before the block runs are dropped
      gen_irq_ff <= 1'b0;
    end else begin
      // keeps tracking updates in suspend mode, so a switch back shows pending news
      gen_irq_ff <= nxt_gen_irq;
    end
  end

  // one register stage keeps decode glitches off the pin
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pull_low_ff <= 1'b0;
    end else begin
      pull_low_ff <= nxt_pull_low;
    end
  end

  // open drain: the data level is fixed low and only the enable moves,
  // so the pin can never fight the external pull-up
  assign irq_pin_out = 1'b0;
  assign irq_pin_oe = pull_low_ff;
endmodule

/* File: testbench/hub_pin_chk_assertions.sv */
module hub_pin_chk #(parameter int NUM_PORTS = 3) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic irq_pin_function_select,
  input wire logic status_update,
  input wire logic irq_status_write,
  input wire logic hub_configured,
  input wire logic hub_suspended,
  input wire logic [NUM_PORTS-1:0] strap_port_disabled,
  input wire logic standby,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [1:0] up_ff;
  wire s = irq_pin_function_select;
  wire oe = irq_pin_oe;
  wire act = hub_configured && !hub_suspended;
  // pin logic only runs from the second edge after release
  wire go = &up_ff;
  always_ff @(posedge clk) up_ff <= {up_ff[0], reset_n};
  AST_OD: assert property (!irq_pin_out) else $error("drove high");
  AST_NOSTRAP: assert property (!strap_port_disabled[2]) else $error("port3");
  AST_KEEP: assert property (go && $past(go) |-> $stable(strap_port_disabled))
    else $error("strap moved");
  AST_STBY: assert property (disable iff (1'b0) !reset_n |=> standby)
    else $error("standby");
  AST_SET: assert property (go && !s && status_update |=> oe) else $error("set");
  AST_HOLD: assert property (go && !s && oe && !irq_status_write |=> oe)
    else $error("hold");
  AST_CLR: assert property (go && !s && irq_status_write && !status_update |=> !oe)
    else $error("clear");
  AST_SUSLO: assert property (go && s && !act |=> oe) else $error("low");
  AST_SUSHI: assert property (go && s && act |=> !oe) else $error("high");
  cover property (go && !s && status_update);
  cover property (go && s && !act);
  cover property (strap_port_disabled != 0);
endmodule

bind hub_strap_and_irq_pin hub_pin_chk #(.NUM_PORTS(NUM_PORTS)) chk_u (
  .clk(clk),
  .reset_n(reset_n),
  .irq_pin_function_select(irq_pin_function_select),
  .status_update(status_update),
  .irq_status_write(irq_status_write),
  .hub_configured(hub_configured),
  .hub_suspended(hub_suspended),
  .strap_port_disabled(strap_port_disabled),
  .standby(standby),
  .irq_pin_out(irq_pin_out),
  .irq_pin_oe(irq_pin_oe)
);

/* File: testbench/irq_host_model.sv */
module irq_host_model (
  input wire logic clk,
  input wire logic irq_pin_oe,
  input wire logic clr_en,
  output logic lvl,
  output logic irq_status_write = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  assign lvl = !irq_pin_oe;
  // host clears only after it has seen the pin low
  always @(posedge clk) irq_status_write <= clr_en && !lvl && !irq_status_write;
endmodule

/* File: testbench/hub_strap_and_irq_pin_tb.sv */
module hub_strap_and_irq_pin_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = '0, reset_n = '0, irq_pin_function_select = '0, status_update = '0;
  logic hub_configured = '0, hub_suspended = '0, clr_en = '0, irq_status_write, irq_pin_out;
  logic [2:0] downstream_port_dplus = '0, downstream_port_dminus = '0, strap_port_disabled;
  logic standby, irq_pin_oe, lvl;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  hub_strap_and_irq_pin dut_u (
    .clk(clk),
    .reset_n(reset_n),
    .downstream_port_dplus(downstream_port_dplus),
    .downstream_port_dminus(downstream_port_dminus),
    .irq_pin_function_select(irq_pin_function_select),
    .status_update(status_update),
    .irq_status_write(irq_status_write),
    .hub_configured(hub_configured),
    .hub_suspended(hub_suspended),
    .strap_port_disabled(strap_port_disabled),
    .standby(standby),
    .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe)
  );
  irq_host_model host_u (
    .clk(clk),
    .irq_pin_oe(irq_pin_oe),
    .clr_en(clr_en),
    .lvl(lvl),
    .irq_status_write(irq_status_write)
  );
  task automatic chk(string n, logic [2:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic strap(logic [2:0] p, m, int n);
    @(posedge clk);
    reset_n <= 1'h0;
    status_update <= 1'h1;
    downstream_port_dplus <= p;
    downstream_port_dminus <= m;
    repeat (n) @(posedge clk);
    #1 chk("rst_out", {strap_port_disabled[1:0], irq_pin_oe}, 3'h0);
    chk("rst_stby", {2'h0, standby}, 3'h1);
    @(posedge clk);
    reset_n <= 1'h1;
    status_update <= 1'h0;
    @(posedge clk);
    #1 chk("run_stby", {2'h0, standby}, 3'h0);
    repeat (3) @(posedge clk);
    downstream_port_dplus <= ~p;
    repeat (3) @(posedge clk);
    #1 chk("strap", strap_port_disabled, {1'h0, p[1:0] & m[1:0]});
    chk("rst_irq", {2'h0, irq_pin_oe}, 3'h0);
  endtask
  task automatic irq_general();
    @(posedge clk);
    status_update <= 1'h1;
    @(posedge clk);
    status_update <= 1'h0;
    repeat (4) @(posedge clk);
    #1 chk("held", {1'h0, irq_pin_oe, lvl}, 3'h2);
    @(posedge clk);
    clr_en <= 1'h1;
    repeat (4) @(posedge clk);
    #1 chk("cleared", {1'h0, irq_pin_oe, lvl}, 3'h1);
  endtask
  task automatic irq_suspend();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      irq_pin_function_select <= 1'h1;
      {hub_configured, hub_suspended} <= 2'(i);
      repeat (2) @(posedge clk);
      #1 chk("suspend", {2'h0, irq_pin_oe}, {2'h0, i != 2});
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 300) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    strap(3'h7, 3'h7, 10);
    strap(3'h5, 3'h3, 4);
    irq_general();
    irq_suspend();
    results();
  end
endmodule
